/* File: cnpc_pkg.sv */
/*
  Shared constants of the character/nibble parity codec: register map,
  designator field layout, parity codes, character ranges and states.
  Assumes a 32-bit APB register bus and one 100 MHz clock domain.
*/
package cnpc_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DESIG = 8'h04;
  localparam logic [7:0] OFF_SRC0 = 8'h08;
  localparam logic [7:0] OFF_SRC1 = 8'h0C;
  localparam logic [7:0] OFF_SRC2 = 8'h10;
  localparam logic [7:0] OFF_DST0 = 8'h14;
  localparam logic [7:0] OFF_DST1 = 8'h18;
  localparam logic [7:0] OFF_DST2 = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  // Control and status bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_W = 2;

  // Operation select
  localparam logic OP_N2C = 1'b0;
  localparam logic OP_C2N = 1'b1;

  // Designator fields
  localparam int FLD_W = 4;
  localparam int FLD_PAR_LSB = 12;
  localparam int FLD_SB_LSB = 8;
  localparam int FLD_CNT_LSB = 4;
  localparam int FLD_SD_LSB = 0;
  localparam logic [3:0] PAR_MAX = 4'h2;
  localparam logic [3:0] SB_MAX = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'h3;
  localparam logic [3:0] SD_MAX = 4'h3;

  // Parity modes
  localparam logic [3:0] PAR_NONE = 4'h0;
  localparam logic [3:0] PAR_EVEN = 4'h1;
  localparam logic [3:0] PAR_ODD = 4'h2;

  // Character codes
  localparam logic [3:0] DEC_LIMIT = 4'hA;
  localparam logic [3:0] ALPHA_ADJ = 4'h9;
  localparam logic [6:0] CHAR_DIGIT_BASE = 7'h30;
  localparam logic [6:0] CHAR_ALPHA_BASE = 7'h37;
  localparam logic [6:0] CHAR_DIGIT_LO = 7'h30;
  localparam logic [6:0] CHAR_DIGIT_HI = 7'h39;
  localparam logic [6:0] CHAR_ALPHA_LO = 7'h41;
  localparam logic [6:0] CHAR_ALPHA_HI = 7'h46;
  localparam logic [15:0] NIB_MASK = 16'h000F;

  // Structure
  localparam int LANES = 4;
  localparam int SRC_WORDS = 3;
  localparam int DST_WORDS = 3;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    CNPC_IDLE = 3'b001,
    CNPC_CONV = 3'b010,
    CNPC_DONE = 3'b100
  } cnpc_state_e;
endpackage

/* File: cnpc_lane.sv */
/*
  One conversion lane: nibble to parity-adjusted character, and
  character to nibble with parity and validity checking.
  Purely combinational; the parent registers every result.
*/
`timescale 1ns/100ps
module cnpc_lane (
  // Nibble-to-character side
  input wire logic [3:0] nib_in,
  input wire logic [cnpc_pkg::FLD_W-1:0] par_mode,
  output logic [7:0] char_out,
  // Character-to-nibble side
  input wire logic [7:0] byte_in,
  output logic [3:0] nib_out,
  output logic byte_bad
);
  import cnpc_pkg::*;

  logic [6:0] code; // Seven-bit character before parity
  logic [6:0] low; // Input byte with parity bit dropped
  logic is_digit; // Low bits in digit range
  logic is_alpha; // Low bits in letter range
  logic par_ok; // Parity bit agrees with mode

  // Digit or letter character code
  always_comb begin
    if (nib_in < DEC_LIMIT) begin
      code = CHAR_DIGIT_BASE + 7'(nib_in);
    end else begin
      code = CHAR_ALPHA_BASE + 7'(nib_in);
    end
  end

  // Parity bit in the top position
  always_comb begin
    case (par_mode)
      PAR_EVEN: char_out = {^code, code};
      PAR_ODD: char_out = {~^code, code};
      default: char_out = {1'b0, code};
    endcase
  end

  // Parity bit ignored for the value
  assign low = byte_in[6:0];

  // Accepted character ranges
  assign is_digit = (low >= CHAR_DIGIT_LO) && (low <= CHAR_DIGIT_HI);
  assign is_alpha = (low >= CHAR_ALPHA_LO) && (low <= CHAR_ALPHA_HI);

  // Digit value of the character
  assign nib_out = is_alpha ? (low[3:0] + ALPHA_ADJ) : low[3:0];

  // Parity check per mode
  always_comb begin
    case (par_mode)
      PAR_NONE: par_ok = !byte_in[7];
      PAR_EVEN: par_ok = ~^byte_in;
      PAR_ODD: par_ok = ^byte_in;
      default: par_ok = 1'b0;
    endcase
  end

  // Lane fault: parity or invalid character
  assign byte_bad = !par_ok || !(is_digit || is_alpha);
endmodule

/* File: cnpc_codec.sv */
/*
  Character/nibble parity codec with APB register access. Converts
  source nibbles to parity-adjusted characters, or up to four
  characters back to nibbles with parity and validity checks.
  Assumes an APB master on core_clk and a level interrupt consumer.
*/
`timescale 1ns/100ps
module cnpc_codec (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cnpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [cnpc_pkg::DATA_W-1:0] pwdata,
  output logic [cnpc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);
  import cnpc_pkg::*;

  cnpc_state_e state_reg; // Sequencer state
  cnpc_state_e state_next; // Next sequencer state
  logic op_reg; // Selected operation
  logic [WORD_W-1:0] desig_reg; // Conversion designator
  logic [WORD_W-1:0] src_reg [SRC_WORDS]; // Source words
  logic [WORD_W-1:0] dst_reg [DST_WORDS]; // Destination words
  logic [WORD_W-1:0] dst_next [DST_WORDS]; // Destination after a run
  logic err_reg; // Error flag
  logic [IRQ_W-1:0] irq_stat_reg; // Sticky event bits
  logic [IRQ_W-1:0] irq_stat_next; // Next sticky bits
  logic [IRQ_W-1:0] irq_mask_reg; // Interrupt enables
  logic [IRQ_W-1:0] irq_mask_next; // Next enables
  logic [IRQ_W-1:0] irq_set; // Events this cycle
  logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear bits

  logic [FLD_W-1:0] par_fld; // Parity mode field
  logic [FLD_W-1:0] sb_fld; // Start byte field
  logic [FLD_W-1:0] cnt_fld; // Count minus one field
  logic [FLD_W-1:0] sd_fld; // Start digit field
  logic desig_bad; // Field out of range
  logic any_bad; // Some active lane failed
  logic conv_err; // Run ends in error
  logic busy; // Run in progress
  logic wr_acc; // Write taking effect
  logic start_acc; // Start accepted
  logic [DATA_W-1:0] rd_data; // Read mux
  logic rd_hit; // Address is mapped

  // Per-lane wiring
  logic [1:0] lane_word [LANES]; // Word of byte position
  logic lane_byte [LANES]; // Upper or lower byte
  logic [1:0] lane_dig [LANES]; // Digit position
  logic [LANES-1:0] lane_act; // Lane within count
  logic [3:0] lane_nib_in [LANES]; // Source nibble
  logic [7:0] lane_char [LANES]; // Generated character
  logic [7:0] lane_byte_in [LANES]; // Source character
  logic [3:0] lane_nib_out [LANES]; // Decoded nibble
  logic [LANES-1:0] lane_bad; // Lane check failed
  logic [WORD_W-1:0] keep_mask; // Digits untouched by lane 0

  // Designator fields
  assign par_fld = desig_reg[FLD_PAR_LSB +: FLD_W];
  assign sb_fld = desig_reg[FLD_SB_LSB +: FLD_W];
  assign cnt_fld = desig_reg[FLD_CNT_LSB +: FLD_W];
  assign sd_fld = desig_reg[FLD_SD_LSB +: FLD_W];

  // Range check on every field
  assign desig_bad = (par_fld > PAR_MAX) || (sb_fld > SB_MAX) ||
                     (cnt_fld > CNT_MAX) || (sd_fld > SD_MAX);

  // Bus qualifiers
  assign busy = (state_reg != CNPC_IDLE);
  assign wr_acc = psel && penable && pwrite && pready;
  assign start_acc = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_START_BIT] && !busy;

  // Lanes: byte position, digit position, converters
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [2:0] pos; // Byte position from start byte
    assign pos = {2'b00, sb_fld[0]} + 3'(i);
    assign lane_word[i] = pos[2:1];
    assign lane_byte[i] = pos[0];
    assign lane_dig[i] = 2'(sd_fld[1:0] + 2'(i));
    assign lane_act[i] = (4'(i) <= cnt_fld);
    assign lane_nib_in[i] = src_reg[0][{lane_dig[i], 2'b00} +: 4];
    assign lane_byte_in[i] = src_reg[pos[2:1]][{pos[0], 3'b000} +: 8];
    cnpc_lane u_lane (
      .nib_in(lane_nib_in[i]),
      .par_mode(par_fld),
      .char_out(lane_char[i]),
      .byte_in(lane_byte_in[i]),
      .nib_out(lane_nib_out[i]),
      .byte_bad(lane_bad[i])
    );
  end

  // Outcome of a run
  assign any_bad = |(lane_bad & lane_act);
  assign conv_err = desig_bad || ((op_reg == OP_C2N) && any_bad);

  // Destination contents after a clean run
  always_comb begin
    for (int w = 0; w < DST_WORDS; w++) begin
      dst_next[w] = dst_reg[w];
    end
    if (!conv_err) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_act[i]) begin
          if (op_reg == OP_N2C) begin
            // Lower byte first, then upper, then next word
            dst_next[lane_word[i]][{lane_byte[i], 3'b000} +: 8] = lane_char[i];
          end else begin
            // Only the selected digit changes
            dst_next[0][{lane_dig[i], 2'b00} +: 4] = lane_nib_out[i];
          end
        end
      end
    end
  end

  // Sequencer next state
  always_comb begin
    case (state_reg)
      CNPC_IDLE: state_next = start_acc ? CNPC_CONV : CNPC_IDLE;
      CNPC_CONV: state_next = CNPC_DONE;
      CNPC_DONE: state_next = CNPC_IDLE;
      default: state_next = CNPC_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CNPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operation select and designator, frozen while busy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= OP_N2C;
      desig_reg <= WORD_RST;
    end else if (wr_acc && !busy) begin
      if (paddr == OFF_CTRL) begin
        op_reg <= pwdata[CTRL_OP_BIT];
      end
      if (paddr == OFF_DESIG) begin
        desig_reg <= pwdata[WORD_W-1:0];
      end
    end
  end

  // Source words, frozen while busy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < SRC_WORDS; w++) begin
        src_reg[w] <= WORD_RST;
      end
    end else if (wr_acc && !busy) begin
      // Writes during a run are dropped
      case (paddr)
        OFF_SRC0: src_reg[0] <= pwdata[WORD_W-1:0];
        OFF_SRC1: src_reg[1] <= pwdata[WORD_W-1:0];
        OFF_SRC2: src_reg[2] <= pwdata[WORD_W-1:0];
        default: ;
      endcase
    end
  end

  // Destination words: run result or software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < DST_WORDS; w++) begin
        dst_reg[w] <= WORD_RST;
      end
    end else if (state_reg == CNPC_CONV) begin
      // Errored runs leave everything as it was
      for (int w = 0; w < DST_WORDS; w++) begin
        dst_reg[w] <= dst_next[w];
      end
    end else if (wr_acc && !busy) begin
      case (paddr)
        OFF_DST0: dst_reg[0] <= pwdata[WORD_W-1:0];
        OFF_DST1: dst_reg[1] <= pwdata[WORD_W-1:0];
        OFF_DST2: dst_reg[2] <= pwdata[WORD_W-1:0];
        default: ;
      endcase
    end
  end

  // Error flag: set or cleared by every run
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= 1'b0;
    end else if (state_reg == CNPC_CONV) begin
      err_reg <= conv_err;
    end
  end

  // Interrupt events and clears
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT] = (state_reg == CNPC_CONV);
    irq_set[IRQ_ERR_BIT] = (state_reg == CNPC_CONV) && conv_err;
    irq_clr = '0;
    if (wr_acc && (paddr == OFF_IRQ_STAT)) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    irq_mask_next = irq_mask_reg;
    if (wr_acc && (paddr == OFF_IRQ_MASK)) begin
      irq_mask_next = pwdata[IRQ_W-1:0];
    end
  end

  // Sticky status, mask and interrupt line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq <= |(irq_stat_next & irq_mask_next);
    end
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_data[CTRL_OP_BIT] = op_reg;
      OFF_DESIG: rd_data[WORD_W-1:0] = desig_reg;
      OFF_SRC0: rd_data[WORD_W-1:0] = src_reg[0];
      OFF_SRC1: rd_data[WORD_W-1:0] = src_reg[1];
      OFF_SRC2: rd_data[WORD_W-1:0] = src_reg[2];
      OFF_DST0: rd_data[WORD_W-1:0] = dst_reg[0];
      OFF_DST1: rd_data[WORD_W-1:0] = dst_reg[1];
      OFF_DST2: rd_data[WORD_W-1:0] = dst_reg[2];
      OFF_STATUS: begin
        rd_data[STAT_BUSY_BIT] = busy;
        rd_data[STAT_ERR_BIT] = err_reg;
      end
      OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_reg;
      OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // APB answer, prepared in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? '0 : rd_data;
        pslverr <= !rd_hit;
      end
    end
  end

  // Helper for held-digit check
  assign keep_mask = ~(NIB_MASK << {lane_dig[0], 2'b00});

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Run sequence pieces
  sequence seq_bad_run;
    (state_reg == CNPC_CONV) && conv_err;
  endsequence
  sequence seq_err_report;
    (err_reg && irq_stat_reg[IRQ_ERR_BIT]) ##1 ((state_reg == CNPC_IDLE) && err_reg);
  endsequence
  sequence seq_run;
    (state_reg == CNPC_CONV) ##1 (state_reg == CNPC_DONE) ##1 (state_reg == CNPC_IDLE);
  endsequence

  chk_digit_map: assert property (lane_char[0][6:0] == ((lane_nib_in[0] < DEC_LIMIT) ?
      CHAR_DIGIT_LO + 7'(lane_nib_in[0]) : CHAR_ALPHA_LO + 7'(lane_nib_in[0] - DEC_LIMIT)))
    else $error("character code wrong for nibble");
  chk_none_msb: assert property ((par_fld == PAR_NONE) |-> !lane_char[0][7])
    else $error("bit 7 set without parity");
  chk_even_ones: assert property ((par_fld == PAR_EVEN) |-> !(^lane_char[0]))
    else $error("even parity character has odd ones");
  chk_odd_ones: assert property ((par_fld == PAR_ODD) |-> (^lane_char[0]))
    else $error("odd parity character has even ones");
  chk_start_run: assert property (start_acc |=> seq_run)
    else $error("run did not take three cycles");
  chk_bad_report: assert property (seq_bad_run |=> seq_err_report)
    else $error("error not reported after bad run");
  chk_good_clear: assert property (((state_reg == CNPC_CONV) && !conv_err) |=> !err_reg)
    else $error("error flag not cleared by clean run");
  chk_bad_nowrite: assert property (((state_reg == CNPC_CONV) && (op_reg == OP_C2N) && any_bad)
      |=> $stable(dst_reg[0]))
    else $error("destination written despite bad byte");
  chk_invalid_char: assert property (((state_reg == CNPC_CONV) && (op_reg == OP_C2N) && lane_act[0]
      && (lane_byte_in[0][6:0] > CHAR_ALPHA_HI)) |=> err_reg)
    else $error("invalid character not flagged");
  chk_held_digits: assert property (((state_reg == CNPC_CONV) && (op_reg == OP_C2N) && !conv_err
      && (cnt_fld == '0)) |=> (((dst_reg[0] ^ $past(dst_reg[0])) & $past(keep_mask)) == '0))
    else $error("unselected digits changed");
  chk_irq_level: assert property (irq == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt line disagrees with status");
endmodule

/* File: cnpc_host.sv */
/*
  Requester model standing in for the processor core: an APB master
  that issues one transfer at a time on behalf of the testbench.
  Assumes a slave clocked on core_clk rising edges.
*/
`timescale 1ns/100ps
module cnpc_host (
  // Clock
  input wire logic core_clk,
  // Request side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [cnpc_pkg::ADDR_W-1:0] paddr,
  output logic [cnpc_pkg::DATA_W-1:0] pwdata,
  // Answer side
  input wire logic [cnpc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import cnpc_pkg::*;

  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; operands held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Hold everything until the answering edge
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: tb.sv */
/*
  Self-checking testbench of the codec: register tasks over APB,
  conversion runs in both directions, error and interrupt checks.
  Assumes the requester model cnpc_host drives the bus.
*/
`timescale 1ns/100ps
module tb;
  import cnpc_pkg::*;
  logic core_clk = 1'b0; // 100 MHz clock
  logic rst_n = 1'b0; // Reset held from time zero
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [31:0] rdv; // Last read data
  logic e; // Last error response
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  // Failing cases: source word and designator
  logic [31:0] bad_src [8] = '{32'h4131, 32'h00B0, 32'h0030, 32'h0040, 32'h003A, 32'h0047, 32'h0030, 32'h0030};
  logic [15:0] bad_des [8] = '{16'h1011, 16'h0000, 16'h2000, 16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h3004};

  always #5 core_clk = ~core_clk;

  cnpc_codec cnpc_codec_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  cnpc_host cnpc_host_inst (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Closing report
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Word comparison
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flag comparison
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cnpc_host_inst.xfer(1'b1, a, d, rdv, e);
  endtask
  task automatic rd(input logic [7:0] a);
    cnpc_host_inst.xfer(1'b0, a, 32'h0, rdv, e);
  endtask

  // Start a run, poll until idle, check the error flag
  task automatic run(input logic [15:0] des, input logic op, input logic exp_err);
    int n;
    wr(OFF_DESIG, {16'h0000, des});
    wr(OFF_CTRL, {30'h0, op, 1'b1});
    n = 0;
    rdv = 32'h1;
    while (rdv[STAT_BUSY_BIT] !== 1'b0 && n < 20) begin
      rd(OFF_STATUS);
      n++;
    end
    cmp32(rdv, {30'h0, exp_err, 1'b0});
  endtask

  // Expected character with parity in bit 7
  function automatic logic [7:0] exp_char(input logic [3:0] v, input logic [3:0] m);
    logic [6:0] c;
    c = (v < 4'hA) ? 7'h30 + {3'h0, v} : 7'h37 + {3'h0, v};
    if (m == 4'h1) return {^c, c};
    if (m == 4'h2) return {~^c, c};
    return {1'b0, c};
  endfunction

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Reset state and unmapped access
    rd(OFF_STATUS);
    cmp32(rdv, 32'h0);
    cmp1(irq, 1'b0);
    rd(8'h2C);
    cmp1(e, 1'b1);
    cmp32(rdv, 32'h0);
    // Designator 0121 into preloaded words
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_SRC0, 32'h4A6B);
    wr(OFF_DST0, 32'hFFFF);
    wr(OFF_DST1, 32'hFFFF);
    run(16'h0121, OP_N2C, 1'b0);
    rd(OFF_DST0);
    cmp32(rdv, 32'h36FF);
    rd(OFF_DST1);
    cmp32(rdv, 32'h3441);
    cmp1(irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h1);
    rd(OFF_IRQ_STAT);
    cmp32(rdv, 32'h0);
    cmp1(irq, 1'b0);
    // Every digit under every parity mode, done masked out
    wr(OFF_IRQ_MASK, 32'h2);
    for (int m = 0; m < 3; m++) begin
      for (int v = 0; v < 16; v++) begin
        wr(OFF_SRC0, {28'h0, 4'(v)});
        run({4'(m), 12'h000}, OP_N2C, 1'b0);
        rd(OFF_DST0);
        cmp32({24'h0, rdv[7:0]}, {24'h0, exp_char(4'(v), 4'(m))});
      end
    end
    cmp1(irq, 1'b0);
    // Four characters from the upper byte reach the third word
    wr(OFF_DST2, 32'hFFFF);
    run(16'h0130, OP_N2C, 1'b0);
    rd(OFF_DST1);
    cmp32(rdv, 32'h3030);
    rd(OFF_DST2);
    cmp32(rdv, 32'hFF30);
    // Characters back to digits, held digits and wrap
    wr(OFF_SRC0, 32'h41B1);
    wr(OFF_DST0, 32'h1234);
    run(16'h1011, OP_C2N, 1'b0);
    rd(OFF_DST0);
    cmp32(rdv, 32'h1A14);
    wr(OFF_SRC0, 32'h3700);
    wr(OFF_SRC1, 32'hB046);
    wr(OFF_SRC2, 32'h0043);
    run(16'h2133, OP_C2N, 1'b0);
    rd(OFF_DST0);
    cmp32(rdv, 32'h7C0F);
    // Parity, character and designator faults leave the word alone
    foreach (bad_src[i]) begin
      wr(OFF_SRC0, bad_src[i]);
      run(bad_des[i], OP_C2N, 1'b1);
      rd(OFF_DST0);
      cmp32(rdv, 32'h7C0F);
    end
    cmp1(irq, 1'b1);
    rd(OFF_IRQ_STAT);
    cmp32(rdv, 32'h3);
    wr(OFF_IRQ_STAT, 32'h3);
    // Clean run clears the flag
    wr(OFF_SRC0, 32'h0045);
    run(16'h0000, OP_C2N, 1'b0);
    rd(OFF_DST0);
    cmp32(rdv, 32'h7C0E);
    cmp1(irq, 1'b0);
    wrap_up();
  end
endmodule
